// ==== inc/wd_timer_defines.svh ====
`ifndef WD_TIMER_DEFINES_SVH
`define WD_TIMER_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define WD_CONTROL_OFFSET 8'h00
`define WD_FLAG_REG_OFFSET 8'h04
`define WD_ENABLE_REG_OFFSET 8'h08

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define WD_PASSWORD 8'h5a
`define WD_READ_KEY 8'h69
`define WD_CLEAR_BIT 3
`define WD_CONTROL_RESET 8'h00
`define WD_FLAG_BIT 0
`define WD_ENABLE_BIT 0

// ----------------------------------------
// Interval taps (counter bit that rises)
// ----------------------------------------
`define WD_TAP_DIV32768 4'd15
`define WD_TAP_DIV8192 4'd13
`define WD_TAP_DIV512 4'd9
`define WD_TAP_DIV64 4'd6

// ----------------------------------------
// Timing
// ----------------------------------------
`define WD_INITIAL_INTERVAL_MS 32
`define WD_COUNT_WIDTH 16
`endif

// ==== inc/wd_timer_pkg.sv ====
package wd_timer_pkg;

    typedef enum logic {
        MODE_WATCHDOG = 1'b0,
        MODE_INTERVAL = 1'b1
    } wd_mode_t;

    typedef enum logic [1:0] {
        DIV_32768 = 2'b00,
        DIV_8192 = 2'b01,
        DIV_512 = 2'b10,
        DIV_64 = 2'b11
    } wd_interval_t;

    // Low byte of the control word, bit 7 down to bit 0
    typedef struct packed {
        logic wd_halt;
        logic nmi_edge_select;
        logic nmi_select;
        wd_mode_t wd_mode_select;
        logic wd_count_clear;
        logic wd_clock_select;
        wd_interval_t wd_interval_select;
    } wd_control_t;

    // One-cycle tick per rising edge of each clock source
    typedef struct packed {
        logic aux;
        logic submain;
        logic main_clk;
        logic internal_osc;
    } clock_ticks_t;

    // Clock health and keep-running requests
    typedef struct packed {
        logic aux;
        logic submain;
    } clock_pair_t;

endpackage

// ==== logic/watchdog_interval_timer.sv ====
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`include "wd_timer_defines.svh"

module watchdog_interval_timer
    import wd_timer_pkg::*;
#(
    parameter bit ENHANCED = 1'b1
) (
    // System
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Clock sources
    input wire clock_ticks_t ticks,
    input wire clock_pair_t clock_failed,
    output logic [1:0] keep_clock_on,
    // Interrupt and reset
    input wire logic global_irq_enable,
    input wire logic irq_serviced,
    output logic interval_irq,
    output logic power_up_clear,
    output logic pin_nmi_function,
    output logic pin_nmi_falling
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    wd_control_t control;
    logic [`WD_COUNT_WIDTH-1:0] wd_count;
    logic [`WD_COUNT_WIDTH-1:0] next_count;
    logic from_internal_osc;
    logic wd_flag;
    logic wd_irq_enable;
    logic puc_pending;

    logic bus_req;
    logic write_ctrl;
    logic write_flag;
    logic write_enable;
    logic key_violation;
    logic wd_tick;
    logic [3:0] tap;
    logic expire;
    logic watchdog_mode;
    wd_control_t written;

    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign write_ctrl = bus_req & we_i & (adr_i == `WD_CONTROL_OFFSET);
    assign write_flag = bus_req & we_i & (adr_i == `WD_FLAG_REG_OFFSET)
        & sel_i[0];
    assign write_enable = bus_req & we_i & (adr_i == `WD_ENABLE_REG_OFFSET)
        & sel_i[0];
    assign written = wd_control_t'(dat_i[7:0]);
    assign watchdog_mode = (control.wd_mode_select == MODE_WATCHDOG);

    // A write without byte lane 1 (sel_i[1]) cannot carry the password, so it is a violation too
    assign key_violation = write_ctrl
        & ((dat_i[15:8] != `WD_PASSWORD) | ~sel_i[1]);

    // ----------------------------------------
    // Clock source selection
    // ----------------------------------------
    always_comb begin
        if (from_internal_osc) begin
            wd_tick = ticks.internal_osc;
        end else if (control.wd_clock_select) begin
            if (ENHANCED && watchdog_mode && clock_failed.aux) begin
                wd_tick = ticks.main_clk;
            end else begin
                wd_tick = ticks.aux;
            end
        end else begin
            if (ENHANCED && watchdog_mode && clock_failed.submain) begin
                wd_tick = ticks.main_clk;
            end else begin
                wd_tick = ticks.submain;
            end
        end
    end

    // Forced clock only in watchdog mode, never in interval mode
    always_comb begin
        keep_clock_on = 2'b00;
        if (ENHANCED && watchdog_mode && !from_internal_osc) begin
            keep_clock_on[1] = control.wd_clock_select;
            keep_clock_on[0] = ~control.wd_clock_select;
        end
    end

    // ----------------------------------------
    // Interval tap and expiry
    // ----------------------------------------
    always_comb begin
        case (control.wd_interval_select)
            DIV_32768: tap = `WD_TAP_DIV32768;
            DIV_8192: tap = `WD_TAP_DIV8192;
            DIV_512: tap = `WD_TAP_DIV512;
            DIV_64: tap = `WD_TAP_DIV64;
            default: tap = `WD_TAP_DIV32768;
        endcase
    end

    assign next_count = wd_count + 16'h0001;
    assign expire = wd_tick & ~control.wd_halt & ~wd_count[tap]
        & next_count[tap];

    // ----------------------------------------
    // Power-up clear request
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            puc_pending <= 1'b0;
        end else if (clk_en) begin
            puc_pending <= key_violation
                | (expire & watchdog_mode & ~puc_pending);
        end
    end

    assign power_up_clear = puc_pending;

    // ----------------------------------------
    // Control word
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            control <= wd_control_t'(`WD_CONTROL_RESET);
            from_internal_osc <= 1'b1;
        end else if (clk_en) begin
            if (puc_pending) begin
                control <= wd_control_t'(`WD_CONTROL_RESET);
                from_internal_osc <= 1'b1;
            end else if (write_ctrl && !key_violation) begin
                control <= written;
                control.wd_count_clear <= 1'b0;
                from_internal_osc <= 1'b0;
            end
        end
    end

    assign pin_nmi_function = control.nmi_select;
    assign pin_nmi_falling = control.nmi_edge_select;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_count <= 16'h0000;
        end else if (clk_en) begin
            if (puc_pending) begin
                wd_count <= 16'h0000;
            end else if (write_ctrl && !key_violation
                         && written.wd_count_clear) begin
                wd_count <= 16'h0000;
            end else if (wd_tick && !control.wd_halt) begin
                wd_count <= next_count;
            end
        end
    end

    // ----------------------------------------
    // Flag and interrupt enable
    // ----------------------------------------
    // No reset but the outer one clears the flag, so it survives a
    // power-up clear that this block itself requests.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_flag <= 1'b0;
        end else if (clk_en) begin
            if (key_violation || expire) begin
                wd_flag <= 1'b1;
            end else if (write_flag) begin
                wd_flag <= dat_i[`WD_FLAG_BIT];
            end else if (irq_serviced && interval_irq) begin
                wd_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_irq_enable <= 1'b0;
        end else if (clk_en) begin
            if (puc_pending) begin
                wd_irq_enable <= 1'b0;
            end else if (write_enable) begin
                wd_irq_enable <= dat_i[`WD_ENABLE_BIT];
            end
        end
    end

    // Watchdog mode reports through the reset vector instead
    assign interval_irq = wd_flag & wd_irq_enable & global_irq_enable
        & ~watchdog_mode;

    // ----------------------------------------
    // Wishbone answer
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_o <= 1'b0;
        end else if (clk_en) begin
            ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dat_o <= 32'h0000_0000;
        end else if (clk_en && bus_req) begin
            if (adr_i == `WD_CONTROL_OFFSET) begin
                dat_o <= {16'h0000, `WD_READ_KEY, control};
            end else if (adr_i == `WD_FLAG_REG_OFFSET) begin
                dat_o <= {31'h0000_0000, wd_flag};
            end else if (adr_i == `WD_ENABLE_REG_OFFSET) begin
                dat_o <= {31'h0000_0000, wd_irq_enable};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

endmodule

// ==== dv/wd_checker_sva.sv ====
`timescale 1ns/1ns
module wd_checker
    import wd_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bus
    input wire logic clk_en,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Events
    input wire clock_ticks_t ticks,
    input wire logic global_irq_enable,
    input wire logic irq_serviced,
    input wire logic interval_irq,
    input wire logic power_up_clear,
    input wire logic pin_nmi_function
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
wire take = cyc_i && stb_i && !ack_o && clk_en;
wire rack = ack_o && !we_i;
a_ack_follows: assert property (take |=> ack_o)
    else $error("ack missing");
a_ack_single: assert property (ack_o && clk_en |=> !ack_o)
    else $error("ack too long");
a_bad_key: assert property (take && we_i && adr_i == 8'h00
    && dat_i[15:8] != 8'h5a |-> ##[1:2] power_up_clear)
    else $error("no reset on bad key");
a_puc_pulse: assert property (power_up_clear |=> !power_up_clear)
    else $error("reset pulse too long");
a_read_key: assert property (rack && adr_i == 8'h00
    |-> dat_o[15:8] == 8'h69 && !dat_o[3])
    else $error("bad control readback");
a_unmapped_zero: assert property (rack && adr_i == 8'h0c |-> dat_o == 0)
    else $error("unmapped read not zero");
a_irq_gated: assert property (interval_irq |-> global_irq_enable)
    else $error("irq without global enable");
a_service_clear: assert property (interval_irq && irq_serviced
    && ticks == '0 |=> !interval_irq)
    else $error("flag kept after service");
a_puc_pin: assert property (power_up_clear |=> !pin_nmi_function)
    else $error("pin not back to reset");
cover property (power_up_clear);
cover property (interval_irq && irq_serviced);
cover property (rack && adr_i == 8'h00);
endmodule
bind watchdog_interval_timer wd_checker u_chk (.*);

// ==== dv/tb.sv ====
`timescale 1ns/1ns
module tb
    import wd_timer_pkg::*;
;
logic clk, reset, clk_en, cyc_i, stb_i, we_i, ack_o, irq_serviced;
logic [7:0] adr_i;
logic [3:0] sel_i;
logic [31:0] dat_i, dat_o, q;
logic global_irq_enable, interval_irq, power_up_clear;
logic pin_nmi_function, pin_nmi_falling;
logic [1:0] keep_clock_on;
clock_ticks_t ticks;
clock_pair_t clock_failed;
int failures = 0;
int tests_run = 0;
int pucs = 0;
int base;
int dv[4] = '{32768, 8192, 512, 64};
logic [15:0] bad[3] = '{16'h3370, 16'h5b00, 16'h5a00};
localparam clock_ticks_t AUX = 4'h8;
localparam clock_ticks_t SUB = 4'h4;
localparam clock_ticks_t MAIN = 4'h2;
watchdog_interval_timer uut (.clk(clk), .reset(reset), .clk_en(clk_en),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ticks(ticks), .clock_failed(clock_failed),
    .keep_clock_on(keep_clock_on), .global_irq_enable(global_irq_enable),
    .irq_serviced(irq_serviced), .interval_irq(interval_irq),
    .power_up_clear(power_up_clear), .pin_nmi_function(pin_nmi_function),
    .pin_nmi_falling(pin_nmi_falling));
initial begin
    clk = 0;
    forever #20 clk = ~clk;
end
always @(posedge clk) if (power_up_clear === 1'b1) pucs <= pucs + 1;
task end_of_test;
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
        failures++;
        $display("[FAIL] %s exp %h got %h", n, e, g);
    end
endtask
task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    i = 0;
    do begin
        @(posedge clk);
        i++;
    end while (ack_o !== 1'b1 && i < 16);
    if (ack_o !== 1'b1) begin
        failures++;
        end_of_test;
    end
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk);
endtask
task wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, {16'h0, d});
endtask
task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, e, q);
endtask
task tk(input int n, input clock_ticks_t t);
    repeat (n) begin
        ticks <= t;
        @(posedge clk);
    end
    ticks <= '0;
    @(posedge clk);
endtask
initial begin
    {cyc_i, stb_i, we_i, irq_serviced} = 0;
    {reset, clk_en, global_irq_enable, sel_i} = 7'h7f;
    {adr_i, dat_i, ticks, clock_failed} = 0;
    repeat (90000) @(posedge clk);
    failures++;
    end_of_test;
end
initial begin
    repeat (12) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rd(8'h00, 32'h6900, "ctl_reset");
    rd(8'h0c, 0, "unmapped");
    wr(8'h08, 16'h0001);
    wr(8'h00, 16'h5a1f);
    rd(8'h00, 32'h6917, "ctl_ival");
    tk(100, SUB);
    rd(8'h04, 0, "sub_ignored");
    tk(63, AUX);
    rd(8'h04, 0, "early");
    tk(1, AUX);
    rd(8'h04, 1, "ival_flag");
    @(negedge clk);
    chk("irq", 1, interval_irq);
    chk("keep_ival", 0, keep_clock_on);
    @(posedge clk);
    global_irq_enable <= 0;
    @(negedge clk);
    chk("irq_gie", 0, interval_irq);
    @(posedge clk);
    global_irq_enable <= 1;
    rd(8'h08, 1, "enable_kept");
    irq_serviced <= 1;
    @(posedge clk);
    irq_serviced <= 0;
    rd(8'h04, 0, "serviced");
    wr(8'h00, 16'h5a9f);
    tk(100, AUX);
    rd(8'h04, 0, "held");
    wr(8'h00, 16'h5a17);
    tk(64, AUX);
    rd(8'h04, 1, "resumed");
    wr(8'h04, 16'h0);
    rd(8'h04, 0, "sw_clear");
    wr(8'h00, 16'h5a1f);
    clk_en <= 0;
    tk(100, AUX);
    clk_en <= 1;
    rd(8'h04, 0, "frozen");
    for (int c = 0; c < 4; c++) begin
        wr(8'h00, 16'h5a1c | 16'(c));
        tk(dv[c] - 1, AUX);
        rd(8'h04, 0, "div_early");
        tk(1, AUX);
        rd(8'h04, 1, "div_hit");
        wr(8'h04, 16'h0);
    end
    base = pucs;
    wr(8'h00, 16'h5a0f);
    @(negedge clk);
    chk("keep_aux", 2'b10, keep_clock_on);
    @(posedge clk);
    tk(63, AUX);
    chk("no_puc", base, pucs);
    tk(1, AUX);
    repeat (2) @(posedge clk);
    chk("puc_expiry", base + 1, pucs);
    rd(8'h04, 1, "wd_flag");
    rd(8'h00, 32'h6900, "ctl_puc");
    rd(8'h08, 0, "enable_puc");
    wr(8'h00, 16'h5a8c);
    clock_failed <= 2'b10;
    wr(8'h00, 16'h5a0f);
    tk(64, MAIN);
    repeat (2) @(posedge clk);
    chk("failsafe", base + 2, pucs);
    clock_failed <= 2'b00;
    for (int c = 0; c < 3; c++) begin
        wr(8'h04, 16'h0);
        wr(8'h00, 16'h5a70);
        base = pucs;
        @(negedge clk);
        chk("pins", 1, pin_nmi_function & pin_nmi_falling);
        @(posedge clk);
        if (c == 2) sel_i <= 4'h1;
        wr(8'h00, bad[c]);
        sel_i <= 4'hf;
        repeat (2) @(posedge clk);
        chk("puc_key", base + 1, pucs);
        rd(8'h04, 1, "key_flag");
        @(negedge clk);
        chk("pin_reset", 0, pin_nmi_function);
        @(posedge clk);
    end
    end_of_test;
end
endmodule
